// ### spi_erase_pkg.sv
package spi_erase_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] PAGE_ERASE_OP       = 8'h42;
  localparam logic [7:0] CHIP_ERASE_OP_A     = 8'h60;
  localparam logic [7:0] CHIP_ERASE_OP_B     = 8'hC7;
  localparam logic [7:0] POWER_DOWN_OP       = 8'hB9;
  localparam logic [7:0] RESUME_OP           = 8'hAB;
  localparam logic [7:0] ULTRA_SLEEP_OP      = 8'h79;
  localparam logic [7:0] WRITE_ENABLE_OP     = 8'h06;
  localparam logic [7:0] READ_STATUS_OP      = 8'h05;
  // ==========================================================
  // Frame layout
  localparam int         OPCODE_BITS         = 8;
  localparam int         ADDR_BITS           = 16;
  localparam int         PAGE_OFFSET_BITS    = 6;
  localparam int         PAGE_BYTES          = 32;
  localparam int         STATUS_WIP_BIT      = 0;
  localparam logic [3:0] RESET_PATTERN       = 4'h5;
  // ==========================================================
  // Timing
  localparam int         CLK_PERIOD_NS       = 50;
  localparam int         RESUME_DELAY_US     = 75;
  localparam int         RESUME_DELAY_CYC    =
    (RESUME_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         PAGE_ERASE_US       = 1500;
  localparam int         CHIP_ERASE_US       = 50000;
  localparam int         PAGE_ERASE_CYC      = PAGE_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int         CHIP_ERASE_CYC      = CHIP_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int         TIMER_BITS          = 24;
endpackage : spi_erase_pkg

// ### spi_erase_ctrl.sv
`timescale 1ns/100ps
// What this block does
// RULE_01 - Page erase 42h sets page to ones
// RULE_02 - Page erase needs write enable latch
// RULE_03 - Latch sets on chip select rise
// RULE_04 - Two address bytes, low six ignored
// RULE_05 - Page erase starts at chip select rise
// RULE_06 - Busy bit shows running page erase
// RULE_07 - Chip erase on 60h or C7h
// RULE_08 - Chip erase needs latch, shows busy
// RULE_09 - B9h then chip select rise: power-down
// RULE_10 - Power-down ignores all but resume
// RULE_11 - Resume acts on eighth clock edge
// RULE_12 - 79h enters ultra sleep, extra ignored
// RULE_13 - Ultra sleep ignores every serial command
// RULE_14 - Short ultra sleep opcode is abandoned
// RULE_15 - Ultra sleep refused while busy
// RULE_16 - Power-up gives standby and defaults
// RULE_17 - Hardware reset wakes and resets device
// RULE_18 - Host holds serial clock still
// RULE_19 - Sample serial input on chip select rise
// RULE_20 - Pattern 0101 over four pulses resets
// RULE_21 - Any clock edge cancels reset pattern
// RULE_22 - Host sets input with chip select
// RULE_23 - Output undriven until first clock edge
// RULE_24 - Host should reset after power-up
// RULE_25 - Busy flag is status bit zero
// RULE_26 - While busy, only read status accepted
// RULE_27 - Latch clears when internal cycle ends
// RULE_28 - Most significant bit first, rising sample
module spi_erase_ctrl
  import spi_erase_pkg::*;
(
  // System clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Serial link from bus master
  input  wire logic                  sck,
  input  wire logic                  cs_n,
  input  wire logic                  serial_in,
  output logic                       serial_out,
  output logic                       serial_out_en,
  // Array erase port
  output logic                       page_erase_cmd,
  output logic                       chip_erase_cmd,
  output logic [ADDR_BITS-1:0]       erase_addr,
  // Device state
  output logic                       write_in_progress_flag,
  output logic                       write_enable_latch,
  output logic                       power_down_cmd,
  output logic                       ultra_deep_sleep_cmd,
  output logic                       resume_cmd,
  output logic                       ready,
  output logic                       device_reset
);

  typedef enum logic [1:0] {ST_STANDBY, ST_POWER_DOWN, ST_ULTRA} mode_e;

  // ==========================================================
  // Reset release
  logic rst_meta_reg, rst_sync_reg, rst_n;
  // Release synchronised so all system clock flops leave reset on the same edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // ==========================================================
  // Link domain: shift register on serial clock
  // Chip select high clears the count; sck stands still between frames
  logic [5:0]  bit_cnt_reg;
  logic [23:0] shift_reg;
  logic        sck_seen_reg;
  logic [7:0]  shift_next_byte;
  assign shift_next_byte = {shift_reg[6:0], serial_in};

  // RULE_28 MSB-first shifting
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 6'h00;
      shift_reg   <= 24'h000000;
    end else begin
      shift_reg   <= {shift_reg[22:0], serial_in};
      if (bit_cnt_reg != 6'h3F) bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end

  // RULE_23 output held off until first edge
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) sck_seen_reg <= 1'b0;
    else      sck_seen_reg <= 1'b1;
  end

  // Resume toggles on the eighth rising edge, inside the frame
  logic res_tgl_reg;
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) res_tgl_reg <= 1'b0;
    // RULE_11 eighth edge starts resume
    else if (!cs_n && bit_cnt_reg == 6'd7 && shift_next_byte == RESUME_OP)
      res_tgl_reg <= ~res_tgl_reg;
  end

  // ==========================================================
  // Synchronisers into the system clock
  logic [1:0] cs_s, sck_s, sin_s, rt_s;
  logic       cs_d, sck_d, rt_d;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s  <= 2'b11;
      sck_s <= 2'b00;
      sin_s <= 2'b00;
      rt_s  <= 2'b00;
      cs_d  <= 1'b1;
      sck_d <= 1'b0;
      rt_d  <= 1'b0;
    end else begin
      cs_s  <= {cs_s[0], cs_n};
      sck_s <= {sck_s[0], sck};
      sin_s <= {sin_s[0], serial_in};
      rt_s  <= {rt_s[0], res_tgl_reg};
      cs_d  <= cs_s[1];
      sck_d <= sck_s[1];
      rt_d  <= rt_s[1];
    end
  end
  logic cs_rise, cs_fall, sck_edge, res_evt;
  assign cs_rise  = cs_s[1] & ~cs_d;
  assign cs_fall  = ~cs_s[1] & cs_d;
  assign sck_edge = sck_s[1] ^ sck_d;
  assign res_evt  = rt_s[1] ^ rt_d;

  // Opcode is the first byte of the frame; later bits never overwrite it
  logic [7:0]  op_first_reg;
  // RULE_12 opcode kept past eighth bit
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n)                 op_first_reg <= 8'h00;
    else if (bit_cnt_reg == 6'd7) op_first_reg <= shift_next_byte;
  end

  // Frame contents are sampled at chip select rise; the high level then clears shift_reg
  logic [7:0]  op_byte;
  logic [15:0] addr_word;
  assign op_byte   = op_first_reg;
  assign addr_word = shift_reg[15:0];

  // ==========================================================
  // Frame capture in link domain at chip select rise
  logic [7:0]  cap_op_reg;
  logic [15:0] cap_addr_reg;
  logic [5:0]  cap_cnt_reg;
  always_ff @(posedge cs_n or negedge reset_n) begin
    if (!reset_n) begin
      cap_op_reg   <= 8'h00;
      cap_addr_reg <= 16'h0000;
      cap_cnt_reg  <= 6'h00;
    end else begin
      cap_op_reg   <= op_byte;
      cap_addr_reg <= addr_word;
      cap_cnt_reg  <= bit_cnt_reg;
    end
  end

  // ==========================================================
  // Command decode on system clock, one cycle after synced rise
  logic full_op, full_addr;
  assign full_op   = (cap_cnt_reg >= 6'd8);
  assign full_addr = (cap_cnt_reg >= 6'd24);
  logic is_write_enable_cmd, is_perase, is_cerase, is_pd, is_ultra;
  assign is_write_enable_cmd   = full_op && cap_cnt_reg == 6'd8 && cap_op_reg == WRITE_ENABLE_OP;
  assign is_perase = full_addr && cap_op_reg == PAGE_ERASE_OP;
  // RULE_07 both chip erase codes
  assign is_cerase = full_op && cap_cnt_reg == 6'd8 &&
                     (cap_op_reg == CHIP_ERASE_OP_A || cap_op_reg == CHIP_ERASE_OP_B);
  // RULE_09 full power-down opcode
  assign is_pd     = full_op && cap_cnt_reg == 6'd8 && cap_op_reg == POWER_DOWN_OP;
  // RULE_12 extra bits after opcode ignored; RULE_14 short frame abandoned
  assign is_ultra  = full_op && cap_op_reg == ULTRA_SLEEP_OP;

  // ==========================================================
  // Hardware reset detector
  logic [3:0] pat_reg;
  logic [2:0] pulses_reg;
  logic       hw_reset;
  // RULE_19 sample input at chip select rise; RULE_20 match 0101
  // A pulse with any serial clock edge, rising or falling, is no reset pulse
  assign hw_reset = cs_rise && !sck_edge && cap_cnt_reg == 6'd0 && pulses_reg >= 3'd3 &&
                    {pat_reg[2:0], sin_s[1]} == RESET_PATTERN;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pat_reg    <= 4'h0;
      pulses_reg <= 3'd0;
    // RULE_21 clock edge cancels pattern
    end else if (sck_edge || hw_reset || (cs_rise && cap_cnt_reg != 6'd0)) begin
      pat_reg    <= 4'h0;
      pulses_reg <= 3'd0;
    end else if (cs_rise) begin
      pat_reg    <= {pat_reg[2:0], sin_s[1]};
      pulses_reg <= (pulses_reg == 3'd4) ? 3'd4 : pulses_reg + 3'd1;
    end
  end

  // ==========================================================
  // Device state
  mode_e                 mode_reg;
  logic                  wel_reg, busy_reg, pe_reg, ce_reg, pd_reg, ud_reg, rs_reg, rst_pulse;
  logic [TIMER_BITS-1:0] timer_reg;
  logic [15:0]           ready_cnt_reg;
  // cap_* settle at the link edge; decode waits for the synced rise

  always_ff @(posedge clk or negedge rst_n) begin
    // RULE_16 power-up defaults
    if (!rst_n) begin
      mode_reg  <= ST_STANDBY;
      wel_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      timer_reg <= '0;
      pe_reg    <= 1'b0;
      ce_reg    <= 1'b0;
      rs_reg    <= 1'b0;
      rst_pulse <= 1'b0;
      ready_cnt_reg <= 16'h0000;
    // RULE_17 hardware reset restores power-on state
    end else if (hw_reset) begin
      mode_reg  <= ST_STANDBY;
      wel_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      timer_reg <= '0;
      pe_reg    <= 1'b0;
      ce_reg    <= 1'b0;
      rs_reg    <= 1'b0;
      rst_pulse <= 1'b1;
      ready_cnt_reg <= 16'h0000;
    end else begin
      pe_reg    <= 1'b0;
      ce_reg    <= 1'b0;
      rs_reg    <= 1'b0;
      rst_pulse <= 1'b0;
      if (ready_cnt_reg != 16'h0000) ready_cnt_reg <= ready_cnt_reg - 16'h0001;
      // RULE_27 latch clears at cycle end; RULE_25 busy drops
      if (busy_reg) begin
        if (timer_reg == '0) begin
          busy_reg <= 1'b0;
          wel_reg  <= 1'b0;
        end else timer_reg <= timer_reg - TIMER_BITS'(1);
      end
      case (mode_reg)
        ST_STANDBY: begin
          // RULE_26 busy ignores all but status
          if (cs_rise && !busy_reg) begin
            // RULE_03 latch set at chip select rise
            if (is_write_enable_cmd) wel_reg <= 1'b1;
            // RULE_02 RULE_04 RULE_05 page erase start
            else if (is_perase && wel_reg) begin
              pe_reg    <= 1'b1;
              busy_reg  <= 1'b1;
              timer_reg <= TIMER_BITS'(PAGE_ERASE_CYC);
            // RULE_08 chip erase start
            end else if (is_cerase && wel_reg) begin
              ce_reg    <= 1'b1;
              busy_reg  <= 1'b1;
              timer_reg <= TIMER_BITS'(CHIP_ERASE_CYC);
            end else if (is_pd) mode_reg <= ST_POWER_DOWN;
            // RULE_15 refused while busy (outer test)
            else if (is_ultra) mode_reg <= ST_ULTRA;
          end
        end
        // RULE_10 only resume or a hardware reset leaves power-down
        ST_POWER_DOWN: begin
          if (res_evt) begin
            mode_reg      <= ST_STANDBY;
            rs_reg        <= 1'b1;
            ready_cnt_reg <= 16'(RESUME_DELAY_CYC);
          end
        end
        // RULE_13 no serial command leaves ultra sleep; only a hardware reset does
        default: mode_reg <= ST_ULTRA;
      endcase
    end
  end

  // Erase address drops the in-page bits
  logic [ADDR_BITS-1:0] addr_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) addr_reg <= '0;
    // RULE_04 in-page bits ignored; RULE_01 whole page
    else if (cs_rise && is_perase) addr_reg <= {cap_addr_reg[15:PAGE_OFFSET_BITS], 6'h00};
  end

  // ==========================================================
  // Outputs
  assign page_erase_cmd         = pe_reg;
  assign chip_erase_cmd         = ce_reg;
  assign erase_addr             = addr_reg;
  // RULE_06 busy reported as status bit
  assign write_in_progress_flag = busy_reg;
  assign write_enable_latch     = wel_reg;
  assign power_down_cmd         = (mode_reg == ST_POWER_DOWN);
  assign ultra_deep_sleep_cmd   = (mode_reg == ST_ULTRA);
  assign resume_cmd             = rs_reg;
  assign ready                  = (ready_cnt_reg == 16'h0000) && !busy_reg &&
                                  (mode_reg == ST_STANDBY);
  assign device_reset           = rst_pulse;
  assign serial_out             = busy_reg;
  assign serial_out_en          = sck_seen_reg && !cs_n && (mode_reg != ST_ULTRA);

  // ==========================================================
  // Checks
  // RULE_09 power-down entry
  a_pd_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && is_pd && !busy_reg && mode_reg == ST_STANDBY) |=> power_down_cmd) // RULE_09
    else $error("power-down not entered");
  // RULE_02 erase needs latch
  a_erase_latch: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy_reg) |-> $past(wel_reg)) // RULE_02
    else $error("erase without latch");
  // RULE_27 latch drops with busy
  a_wel_clear: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(busy_reg) |-> !wel_reg) // RULE_27
    else $error("latch kept after cycle");
  // RULE_13 ultra sleep kept
  a_ultra_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ultra_deep_sleep_cmd && !hw_reset) |=> ultra_deep_sleep_cmd) // RULE_13
    else $error("ultra sleep left");
  // RULE_17 reset clears state
  a_hw_reset: assert property (@(posedge clk) disable iff (!rst_n)
    hw_reset |=> (device_reset && !busy_reg && !wel_reg && !ultra_deep_sleep_cmd)) // RULE_17
    else $error("hardware reset incomplete");
  // RULE_04 page aligned address
  a_page_addr: assert property (@(posedge clk) disable iff (!rst_n)
    page_erase_cmd |-> erase_addr[5:0] == 6'h00) // RULE_04
    else $error("page address unaligned");
  // RULE_10 power-down ignores erase
  a_pd_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    power_down_cmd |=> !$rose(busy_reg)) // RULE_10
    else $error("command ran in power-down");
  // RULE_23 no drive before clock
  a_out_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    serial_out_en |-> sck_seen_reg) // RULE_23
    else $error("output driven early");
  // RULE_03 latch set by full frame
  a_wel_set: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && is_write_enable_cmd && !busy_reg && mode_reg == ST_STANDBY) |=> write_enable_latch) // RULE_03
    else $error("latch not set");
  // RULE_05 page erase starts
  a_erase_start: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && is_perase && wel_reg && !busy_reg && mode_reg == ST_STANDBY) |=> (page_erase_cmd && write_in_progress_flag)) // RULE_05
    else $error("page erase not started");
  // RULE_15 ultra sleep refused busy
  a_ultra_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && is_ultra && busy_reg) |=> !ultra_deep_sleep_cmd) // RULE_15
    else $error("ultra sleep entered while busy");
  // RULE_14 short opcode abandoned
  a_short_ultra: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && !full_op && mode_reg == ST_STANDBY) |=> !ultra_deep_sleep_cmd) // RULE_14
    else $error("short frame entered ultra sleep");
  // RULE_26 busy keeps standby
  a_busy_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && busy_reg && mode_reg == ST_STANDBY) |=> (mode_reg == ST_STANDBY)) // RULE_26
    else $error("command accepted while busy");
  // RULE_11 resume steps
  sequence s_resume_seen;
    res_evt && mode_reg == ST_POWER_DOWN && !hw_reset;
  endsequence
  sequence s_wake_up;
    resume_cmd && !power_down_cmd && !ready;
  endsequence
  a_resume_wake: assert property (@(posedge clk) disable iff (!rst_n)
    s_resume_seen |=> s_wake_up) // RULE_11
    else $error("resume did not wake");

endmodule : spi_erase_ctrl

// ### spi_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Bus master model on the serial link, mode 0
module spi_host_model (
  // Frame alignment clock
  input  wire logic clk,
  // Serial link to the device
  output logic      sck,
  output logic      cs_n,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_en
);
  // Link idle: clock low, device deselected
  initial begin
    sck       = 1'b0;
    cs_n      = 1'b1;
    serial_in = 1'b1;
  end

  // ==========================================================
  // Frame of n bits, left aligned in d; rx holds the last 8 bits read
  // MSB first, rising sample
  task automatic send(input logic [23:0] d, input int n, output logic [7:0] rx,
                      output logic early_en);
    rx = 8'h00;
    @(posedge clk);
    cs_n      <= 1'b0;
    serial_in <= d[23];
    // Odd offset keeps the link clock out of phase with clk
    #113;
    early_en = serial_out_en;
    for (int i = 0; i < n; i++) begin
      serial_in = d[23-i];
      #32 sck = 1'b1;
      rx = {rx[6:0], serial_out};
      #32 sck = 1'b0;
    end
    #32;
    @(posedge clk);
    cs_n      <= 1'b1;
    // Released line must not keep its last value
    serial_in <= ~serial_in;
    repeat (8) @(posedge clk);
  endtask : send

  // ==========================================================
  // Four select pulses carrying pat; glitch picks a pulse with a clock edge
  // still clock, input with select
  task automatic hw_reset(input logic [3:0] pat, input int glitch);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cs_n      <= 1'b0;
      serial_in <= pat[3-k];
      repeat (4) @(posedge clk);
      if (k == glitch) begin
        #13 sck = 1'b1;
        #32 sck = 1'b0;
      end
      @(posedge clk);
      cs_n <= 1'b1;
      repeat (6) @(posedge clk);
    end
    serial_in <= ~serial_in;
  endtask : hw_reset
endmodule : spi_host_model

// ### spi_eeprom_erase_power_reset_tb.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the erase and power control
module spi_eeprom_erase_power_reset_tb import spi_erase_pkg::*;;
  logic                 clk;
  logic                 reset_n = 1'b0;
  logic                 sck, cs_n, serial_in, serial_out, serial_out_en;
  logic                 page_erase_cmd, chip_erase_cmd, write_in_progress_flag;
  logic [ADDR_BITS-1:0] erase_addr;
  logic                 write_enable_latch, power_down_cmd, ultra_deep_sleep_cmd;
  logic                 resume_cmd, ready, device_reset;
  logic [7:0]           last_rx;
  logic                 last_en;
  int                   mismatches = 0, cmp_count = 0, cnt, n;
  int                   pe_cnt = 0, ce_cnt = 0, rs_cnt = 0, hr_cnt = 0;
  localparam logic [15:0] PAGE_ADDR = 16'h1234;

  spi_erase_ctrl i_dut (.clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .page_erase_cmd(page_erase_cmd), .chip_erase_cmd(chip_erase_cmd),
    .erase_addr(erase_addr), .write_in_progress_flag(write_in_progress_flag),
    .write_enable_latch(write_enable_latch), .power_down_cmd(power_down_cmd),
    .ultra_deep_sleep_cmd(ultra_deep_sleep_cmd), .resume_cmd(resume_cmd),
    .ready(ready), .device_reset(device_reset));
  spi_host_model i_host (.clk(clk), .sck(sck), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en));

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulse counters, so one-cycle outputs are never missed
  always @(posedge clk) begin
    pe_cnt <= pe_cnt + int'(page_erase_cmd === 1'b1);
    ce_cnt <= ce_cnt + int'(chip_erase_cmd === 1'b1);
    rs_cnt <= rs_cnt + int'(resume_cmd === 1'b1);
    hr_cnt <= hr_cnt + int'(device_reset === 1'b1);
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic frame(input logic [23:0] d, input int bits);
    i_host.send(d, bits, last_rx, last_en);
    #1;
  endtask : frame

  task automatic do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask : do_reset

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Scenarios
  task automatic t_power_on;
    check("flag", write_in_progress_flag, 0);
    check("latch", write_enable_latch, 0);
    check("ready", ready, 1);
    cnt = hr_cnt;
    i_host.hw_reset(RESET_PATTERN, -1);
    repeat (8) @(posedge clk);
    #1;
    check("hw reset", hr_cnt, cnt + 1);
    $display("power-on test done");
  endtask : t_power_on

  task automatic t_page_erase;
    cnt = pe_cnt;
    frame({PAGE_ERASE_OP, PAGE_ADDR}, 24);
    check("erase unlatched", pe_cnt, cnt);
    frame({WRITE_ENABLE_OP, 16'h0000}, 8);
    check("latch set", write_enable_latch, 1);
    frame({PAGE_ERASE_OP, PAGE_ADDR}, 24);
    check("page erase", pe_cnt, cnt + 1);
    check("page addr", erase_addr, {PAGE_ADDR[15:6], 6'h00});
    check("busy", write_in_progress_flag, 1);
    frame({READ_STATUS_OP, 16'h0000}, 16);
    check("status busy", last_rx[STATUS_WIP_BIT], 1);
    check("early drive", last_en, 0);
    frame({ULTRA_SLEEP_OP, 16'h0000}, 8);
    check("sleep while busy", ultra_deep_sleep_cmd, 0);
    frame({POWER_DOWN_OP, 16'h0000}, 8);
    check("down while busy", power_down_cmd, 0);
    n = 0;
    while (write_in_progress_flag !== 1'b0 && n < PAGE_ERASE_CYC + 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    #1;
    check("busy ends", write_in_progress_flag, 0);
    check("latch cleared", write_enable_latch, 0);
    frame({READ_STATUS_OP, 16'h0000}, 16);
    check("status idle", last_rx[STATUS_WIP_BIT], 0);
    $display("page erase test done");
  endtask : t_page_erase

  task automatic t_chip_erase;
    logic [7:0] ops [2] = '{CHIP_ERASE_OP_A, CHIP_ERASE_OP_B};
    // Both opcodes; a system reset ends each long erase early
    foreach (ops[i]) begin
      do_reset();
      cnt = ce_cnt;
      frame({WRITE_ENABLE_OP, 16'h0000}, 8);
      frame({ops[i], 16'h0000}, 8);
      check("chip erase", ce_cnt, cnt + 1);
      check("chip busy", write_in_progress_flag, 1);
    end
    do_reset();
    $display("chip erase test done");
  endtask : t_chip_erase

  task automatic t_power_down;
    frame({POWER_DOWN_OP, 16'h0000}, 8);
    check("power down", power_down_cmd, 1);
    frame({WRITE_ENABLE_OP, 16'h0000}, 8);
    check("latch in down", write_enable_latch, 0);
    cnt = rs_cnt;
    frame({RESUME_OP, 16'h0000}, 8);
    check("resume", rs_cnt, cnt + 1);
    check("awake", power_down_cmd, 0);
    n = 0;
    while (ready !== 1'b1 && n < RESUME_DELAY_CYC + 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("resume delay", (n > RESUME_DELAY_CYC - 40) && (n <= RESUME_DELAY_CYC), 1);
    $display("power-down test done");
  endtask : t_power_down

  task automatic t_ultra_sleep;
    frame({ULTRA_SLEEP_OP, 16'h0000}, 7);
    check("short opcode", ultra_deep_sleep_cmd, 0);
    frame({ULTRA_SLEEP_OP, 8'hFF, 8'h00}, 16);
    check("ultra sleep", ultra_deep_sleep_cmd, 1);
    cnt = rs_cnt;
    frame({RESUME_OP, 16'h0000}, 8);
    check("resume ignored", rs_cnt, cnt);
    cnt = hr_cnt;
    i_host.hw_reset(4'hA, -1);
    i_host.hw_reset(RESET_PATTERN, 2);
    repeat (8) @(posedge clk);
    #1;
    check("no hw reset", hr_cnt, cnt);
    check("still asleep", ultra_deep_sleep_cmd, 1);
    i_host.hw_reset(RESET_PATTERN, -1);
    repeat (8) @(posedge clk);
    #1;
    check("wake reset", hr_cnt, cnt + 1);
    check("woken", ultra_deep_sleep_cmd, 0);
    $display("ultra sleep test done");
  endtask : t_ultra_sleep

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    t_power_on();
    t_page_erase();
    t_chip_erase();
    t_power_down();
    t_ultra_sleep();
    stop_test();
  end

  // Watchdog, about two and a half times the expected run
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule : spi_eeprom_erase_power_reset_tb
